// File: logic/aar_core.sv
// Auto-answer ring counter and command-character registers.
`timescale 1ns/10ps

// Functional notes
// (RQ1) Hold an 8-bit ring number on which incoming calls get answered.
// (RQ2) Ring number takes 0 to 255 and resets to 0.
// (RQ3) Ring number 1 to 255 enables automatic answer.
// (RQ4) Ring number 0 disables automatic answer entirely.
// (RQ5) Ring counter, reset to 0, counts each ring cycle.
// (RQ6) Ring counter clears after eight seconds without any ring cycle.
// (RQ7) Incoming-call report from the exchange generates internal ring cycles, each counted.
// (RQ8) Answer when enabled and ring count equals the ring number.
// (RQ9) Ring counter saturates at 255.
// (RQ10) Escape register holds the code compared against data-mode traffic.
// (RQ11) Escape register resets to 43; 0 to 127 are valid escapes.
// (RQ12) Escape value above 127 disables escape detection.
// (RQ13) Terminal-ready line still switches to command mode when escape disabled.
// (RQ14) Terminator register takes 0 to 127 and resets to 13.
// (RQ15) Terminator character ends a command line and starts its execution.
// (RQ16) Each result code is followed by the terminator character.
module aar_core
  import aar_pkg::*;
#(
  parameter int unsigned RING_PERIOD_CYCLES = aar_pkg::RING_PERIOD_S * aar_pkg::SECOND_CYCLES,
  parameter int unsigned IDLE_CYCLES        = aar_pkg::RING_IDLE_S * aar_pkg::SECOND_CYCLES
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       reg_wr_i,
  input  wire logic [1:0] reg_sel_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       call_alert_i,
  output logic            ring_ind_o,
  output logic            answer_o,
  input  wire logic       data_mode_i,
  input  wire logic       data_valid_i,
  input  wire logic [7:0] data_char_i,
  output logic            escape_hit_o,
  input  wire logic       dtr_cmd_sel_i,
  input  wire logic       dtr_drop_i,
  output logic            dtr_cmd_o,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_char_i,
  output logic            line_exec_o,
  input  wire logic       result_valid_i,
  input  wire logic [7:0] result_char_i,
  input  wire logic       result_last_i,
  output logic            result_ready_o,
  output logic            tx_valid_o,
  output logic      [7:0] tx_char_o,
  input  wire logic       tx_ready_i
);
  import aar_pkg::*;

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       ring_number;
    logic [7:0]       ring_count;
    logic [7:0]       escape_code;
    logic [7:0]       terminator;
    logic [31:0]      ring_timer;
    logic [31:0]      idle_timer;
    logic             ring_ind;
    logic             answer;
    logic             escape_hit;
    logic             dtr_cmd;
    logic             line_exec;
    logic [2:0]       alert_sync;
    logic             alert_level;
    aar_tx_state_type tx_state;
    logic [7:0]       tx_char;
    logic             tx_valid;
  } aar_state_type;

  aar_state_type st_reg;
  aar_state_type st_next;
  logic          ring_tick;
  logic          auto_enable;

  assign auto_enable    = (st_reg.ring_number != RING_NUMBER_RST); // see (RQ3) see (RQ4)
  assign ring_tick      = st_reg.alert_level && (st_reg.ring_timer == 32'h0);
  assign reg_rdata_o    = (reg_sel_i == SEL_RING_NUMBER) ? st_reg.ring_number :
                          (reg_sel_i == SEL_RING_COUNT)  ? st_reg.ring_count  :
                          (reg_sel_i == SEL_ESCAPE)      ? st_reg.escape_code :
                                                           st_reg.terminator;
  assign ring_ind_o     = st_reg.ring_ind;
  assign answer_o       = st_reg.answer;
  assign escape_hit_o   = st_reg.escape_hit;
  assign dtr_cmd_o      = st_reg.dtr_cmd;
  assign line_exec_o    = st_reg.line_exec;
  assign tx_valid_o     = st_reg.tx_valid;
  assign tx_char_o      = st_reg.tx_char;
  assign result_ready_o = (st_reg.tx_state == AAR_IDLE) ||
                          ((st_reg.tx_state == AAR_RESULT) && tx_ready_i);

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  always_comb
  begin
    st_next            = st_reg;
    st_next.answer     = 1'b0;
    st_next.escape_hit = 1'b0;
    st_next.dtr_cmd    = 1'b0;
    st_next.line_exec  = 1'b0;
    st_next.ring_ind   = 1'b0;
    st_next.alert_sync = {st_reg.alert_sync[1:0], call_alert_i};
    if (st_reg.alert_sync[2] == st_reg.alert_sync[1])
    begin
      st_next.alert_level = st_reg.alert_sync[2];
    end
    // The first ring comes at once; later ones follow one ring period apart.
    if (!st_reg.alert_level)
    begin
      st_next.ring_timer = 32'h0;
    end
    else if (ring_tick)
    begin
      st_next.ring_timer = RING_PERIOD_CYCLES - 1;
    end
    else
    begin
      st_next.ring_timer = st_reg.ring_timer - 32'h1;
    end
    if (ring_tick)
    begin
      st_next.ring_ind   = 1'b1; // see (RQ7)
      st_next.idle_timer = 32'h0;
      if (st_reg.ring_count != RING_COUNT_MAX) // see (RQ9)
      begin
        st_next.ring_count = st_reg.ring_count + 8'h01; // see (RQ5)
      end
      if (auto_enable && (st_reg.ring_count + 8'h01 == st_reg.ring_number))
      begin
        st_next.answer = 1'b1; // see (RQ8)
      end
    end
    else if (st_reg.idle_timer >= IDLE_CYCLES - 1)
    begin
      st_next.ring_count = RING_COUNT_RST; // see (RQ6)
      st_next.idle_timer = 32'h0;
    end
    else
    begin
      st_next.idle_timer = st_reg.idle_timer + 32'h1;
    end
    if (reg_wr_i)
    begin
      case (reg_sel_i)
        SEL_RING_NUMBER: st_next.ring_number = reg_wdata_i; // see (RQ1) see (RQ2)
        SEL_ESCAPE:      st_next.escape_code = reg_wdata_i;
        SEL_TERMINATOR:  st_next.terminator  = {1'b0, reg_wdata_i[CHAR_TOP_BIT-1:0] & TERM_FIELD_MASK}; // see (RQ14)
        default:         st_next.ring_count  = st_next.ring_count;
      endcase
    end
    if (data_mode_i && data_valid_i && !st_reg.escape_code[CHAR_TOP_BIT] &&
        (data_char_i == st_reg.escape_code))
    begin
      st_next.escape_hit = 1'b1; // see (RQ10) see (RQ11) see (RQ12)
    end
    if (data_mode_i && dtr_cmd_sel_i && dtr_drop_i)
    begin
      st_next.dtr_cmd = 1'b1; // see (RQ13)
    end
    if (cmd_valid_i && (cmd_char_i == st_reg.terminator))
    begin
      st_next.line_exec = 1'b1; // see (RQ15)
    end
    case (st_reg.tx_state)
      AAR_IDLE:
      begin
        if (result_valid_i)
        begin
          st_next.tx_valid = 1'b1;
          st_next.tx_char  = result_char_i;
          st_next.tx_state = result_last_i ? AAR_TERM : AAR_RESULT;
        end
      end
      AAR_RESULT:
      begin
        if (tx_ready_i)
        begin
          st_next.tx_valid = result_valid_i;
          st_next.tx_char  = result_char_i;
          if (!result_valid_i)
          begin
            st_next.tx_state = AAR_IDLE;
          end
          else if (result_last_i)
          begin
            st_next.tx_state = AAR_TERM;
          end
        end
      end
      AAR_TERM:
      begin
        if (tx_ready_i)
        begin
          st_next.tx_valid = 1'b1;
          st_next.tx_char  = st_reg.terminator; // see (RQ16)
          st_next.tx_state = AAR_RESULT;
        end
      end
      default:
      begin
        st_next.tx_state = AAR_IDLE;
        st_next.tx_valid = 1'b0;
      end
    endcase
  end

  //----------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      st_reg             <= '0;
      st_reg.ring_number <= RING_NUMBER_RST; // see (RQ2)
      st_reg.ring_count  <= RING_COUNT_RST;
      st_reg.escape_code <= ESCAPE_RST; // see (RQ11)
      st_reg.terminator  <= TERMINATOR_RST; // see (RQ14)
      st_reg.tx_state    <= AAR_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  sequence ring_seen_s;
    ring_tick;
  endsequence

  ring_count_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ5)
    ring_seen_s and (st_reg.ring_count != RING_COUNT_MAX) |=>
      st_reg.ring_count == $past(st_reg.ring_count) + 8'h01)
    else $error("Ring count did not step.");
  ring_saturate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ9)
    (st_reg.ring_count == RING_COUNT_MAX) && !(st_reg.idle_timer >= IDLE_CYCLES - 1) |=>
      st_reg.ring_count == RING_COUNT_MAX)
    else $error("Ring count wrapped.");
  ring_pulse_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ7)
    ring_seen_s |=> ring_ind_o)
    else $error("Ring cycle not shown.");
  answer_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ4)
    answer_o |-> $past(st_reg.ring_number) != RING_NUMBER_RST)
    else $error("Answered while disabled.");
  answer_match_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ8)
    ring_seen_s and (auto_enable && (st_reg.ring_count + 8'h01 == st_reg.ring_number))
      |=> answer_o)
    else $error("Missed answer.");
  escape_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ12)
    escape_hit_o |-> !$past(st_reg.escape_code[CHAR_TOP_BIT]))
    else $error("Escape while disabled.");
  line_end_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ15)
    cmd_valid_i && (cmd_char_i == st_reg.terminator) |=> line_exec_o)
    else $error("Terminator ignored.");
  term_follow_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ16)
    (st_reg.tx_state == AAR_TERM) && tx_ready_i |=>
      tx_valid_o && (tx_char_o == $past(st_reg.terminator)))
    else $error("Terminator not sent.");

  // The idle clear needs a long quiet spell, so the idle counter stands in for a repetition.
  ring_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ6)
    !ring_tick && (st_reg.idle_timer >= IDLE_CYCLES - 1) |=>
      st_reg.ring_count == RING_COUNT_RST)
    else $error("Ring count not cleared.");
  ring_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ6)
    !ring_tick && (st_reg.idle_timer < IDLE_CYCLES - 1) |=>
      st_reg.ring_count == $past(st_reg.ring_count))
    else $error("Ring count moved without a ring.");
  answer_ring_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ8)
    answer_o |-> ring_ind_o)
    else $error("Answer without a ring.");
  escape_match_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ10)
    data_mode_i && data_valid_i && !st_reg.escape_code[CHAR_TOP_BIT] &&
      (data_char_i == st_reg.escape_code) |=> escape_hit_o)
    else $error("Escape character missed.");
  dtr_switch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ13)
    data_mode_i && dtr_cmd_sel_i && dtr_drop_i |=> dtr_cmd_o)
    else $error("Terminal-ready switch missed.");
  term_range_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ14)
    !st_reg.terminator[CHAR_TOP_BIT])
    else $error("Terminator above range.");
  // A stalled character must stand, or the terminal would lose part of a result code.
  sequence tx_stall_s;
    tx_valid_o && !tx_ready_i;
  endsequence
  sequence tx_same_s;
    tx_valid_o && $stable(tx_char_o);
  endsequence
  tx_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // see (RQ16)
    tx_stall_s |=> tx_same_s)
    else $error("Stalled character changed.");

endmodule

// File: logic/aar_pkg.sv
// Package with register layout, reset values and timing constants of the auto-answer block.
package aar_pkg;

  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned SEC_NS          = 1000000000;
  localparam int unsigned CLK_PERIOD_NS   = SEC_NS / CLK_HZ;
  localparam int unsigned SECOND_CYCLES   = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned RING_IDLE_S     = 8;
  localparam int unsigned RING_PERIOD_S   = 6;

  localparam logic [1:0] SEL_RING_NUMBER  = 2'h0;
  localparam logic [1:0] SEL_RING_COUNT   = 2'h1;
  localparam logic [1:0] SEL_ESCAPE       = 2'h2;
  localparam logic [1:0] SEL_TERMINATOR   = 2'h3;

  localparam logic [7:0] RING_NUMBER_RST  = 8'h00;
  localparam logic [7:0] RING_COUNT_RST   = 8'h00;
  localparam logic [7:0] RING_COUNT_MAX   = 8'hFF;
  localparam logic [7:0] ESCAPE_RST       = 8'h2B;
  localparam logic [7:0] TERMINATOR_RST   = 8'h0D;
  localparam int unsigned CHAR_TOP_BIT    = 7;
  localparam logic [6:0] TERM_FIELD_MASK  = 7'h7F;

  typedef enum logic [1:0] {
    AAR_IDLE,
    AAR_RESULT,
    AAR_TERM
  } aar_tx_state_type;

endpackage

// File: bench/aar_far_end.sv
// Far-side model: exchange call alert and a terminal sink that stalls.
`timescale 1ns/10ps
module aar_far_end
(
  input  wire logic       sys_clk_i,
  input  wire logic       ring_req_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_char_i,
  output logic            call_alert_o,
  output logic            tx_ready_o,
  output logic      [7:0] last_char_o,
  output logic      [7:0] prev_char_o,
  output int              n_char_o
);
  initial
  begin
    call_alert_o = 1'b0;
    tx_ready_o = 1'b0;
    last_char_o = 8'h00;
    prev_char_o = 8'h00;
    n_char_o = 0;
  end
  // Random stalls make the stream prove that a character stands until taken.
  always @(posedge sys_clk_i)
  begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
    begin
      prev_char_o <= last_char_o;
      last_char_o <= tx_char_i;
      n_char_o <= n_char_o + 1;
    end
    tx_ready_o <= #1 ($urandom_range(0, 2) != 0);
    call_alert_o <= #1 ring_req_i;
  end
endmodule

// File: bench/tb.sv
// Self-checking testbench of the auto-answer and command-character block.
`timescale 1ns/10ps
module tb;
  import aar_pkg::*;
  localparam int RP = 20;
  localparam int IDLE = 50;
  logic clk, srst, wr, alert_req, dmode, dvalid, dtr_sel, dtr_drop, cvalid, rvalid, rlast;
  logic call_alert, ring_ind, answer, esc_hit, dtr_cmd, line_exec, rready, txv, txr;
  logic [1:0] sel;
  logic [7:0] wdata, rdata, dchar, cchar, rchar, txc, last_c, prev_c, esc, term;
  int n_tx, failures, n_compared, rings, answers, k, i;

  aar_core #(.RING_PERIOD_CYCLES(RP), .IDLE_CYCLES(IDLE)) dut_u (.sys_clk_i(clk),
    .srst_i(srst), .reg_wr_i(wr), .reg_sel_i(sel), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .call_alert_i(call_alert), .ring_ind_o(ring_ind), .answer_o(answer), .data_mode_i(dmode),
    .data_valid_i(dvalid), .data_char_i(dchar), .escape_hit_o(esc_hit),
    .dtr_cmd_sel_i(dtr_sel), .dtr_drop_i(dtr_drop), .dtr_cmd_o(dtr_cmd), .cmd_valid_i(cvalid),
    .cmd_char_i(cchar), .line_exec_o(line_exec), .result_valid_i(rvalid),
    .result_char_i(rchar), .result_last_i(rlast), .result_ready_o(rready),
    .tx_valid_o(txv), .tx_char_o(txc), .tx_ready_i(txr));
  aar_far_end far_u (.sys_clk_i(clk), .ring_req_i(alert_req), .tx_valid_i(txv),
    .tx_char_i(txc), .call_alert_o(call_alert), .tx_ready_o(txr), .last_char_o(last_c),
    .prev_char_o(prev_c), .n_char_o(n_tx));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [1:0] s, input logic [7:0] d);
    sel = s;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] s, input logic [7:0] exp);
    sel = s;
    #1;
    check(rdata, exp);
  endtask
  task automatic pulse(ref logic v);
    v = 1'b1;
    step(1);
    v = 1'b0;
  endtask
  function automatic logic [7:0] sat(input int n);
    return (n > 255) ? 8'hFF : n[7:0];
  endfunction
  task automatic ring_run(input logic [7:0] num, input int n);
    wr_reg(SEL_RING_NUMBER, num);
    sel = SEL_RING_COUNT;
    rings = 0;
    answers = 0;
    alert_req = 1'b1;
    for (k = 0; k < n * RP + 20 && rings < n; k++)
    begin
      step(1);
      if (ring_ind === 1'b1)
      begin
        rings++;
        check(rdata, sat(rings));
      end
      if (answer === 1'b1)
      begin
        answers++;
        check(sat(rings), num);
      end
    end
    alert_req = 1'b0;
    if (rings < n)
    begin
      failures++;
      wrap_up();
    end
    check(answers[7:0], (num != 8'h00 && num <= sat(n)) ? 8'h01 : 8'h00);
    step(IDLE / 2);
    rd_reg(SEL_RING_COUNT, sat(n));
    step(IDLE + RP);
    rd_reg(SEL_RING_COUNT, 8'h00);
  endtask

  initial
  begin
    void'($urandom(32'h3359a066));
    {wr, alert_req, dmode, dvalid, dtr_sel, dtr_drop, cvalid, rvalid, rlast} = '0;
    {sel, wdata, dchar, cchar, rchar} = '0;
    failures = 0;
    n_compared = 0;
    srst = 1'b1;
    step(10);
    srst = 1'b0;
    rd_reg(SEL_RING_NUMBER, 8'h00);
    rd_reg(SEL_RING_COUNT, 8'h00);
    rd_reg(SEL_ESCAPE, 8'h2B);
    rd_reg(SEL_TERMINATOR, 8'h0D);
    wr_reg(SEL_RING_COUNT, 8'h55);
    rd_reg(SEL_RING_COUNT, 8'h00);
    wr_reg(SEL_RING_NUMBER, 8'hFF);
    rd_reg(SEL_RING_NUMBER, 8'hFF);
    dmode = 1'b1;
    for (i = 0; i < 10; i++)
    begin
      esc = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom_range(0, 255));
      term = 8'($urandom_range(0, 127));
      wr_reg(SEL_ESCAPE, esc);
      rd_reg(SEL_ESCAPE, esc);
      wr_reg(SEL_TERMINATOR, (i == 2) ? 8'hFF : term);
      term = (i == 2) ? 8'h7F : term;
      rd_reg(SEL_TERMINATOR, term);
      dmode = (i != 4);
      dchar = i[0] ? 8'($urandom_range(0, 255)) : esc;
      pulse(dvalid);
      check({7'h00, esc_hit}, {7'h00, dmode && dchar == esc && esc <= 8'h7F});
      cchar = i[0] ? 8'($urandom_range(0, 255)) : term;
      pulse(cvalid);
      check({7'h00, line_exec}, {7'h00, cchar == term});
      dtr_sel = 1'($urandom_range(0, 1));
      pulse(dtr_drop);
      check({7'h00, dtr_cmd}, {7'h00, dmode && dtr_sel});
      rchar = 8'($urandom_range(0, 255));
      rlast = 1'b1;
      rvalid = 1'b1;
      for (k = 0; k < 50 && rready !== 1'b1; k++)
        step(1);
      if (rready !== 1'b1)
      begin
        failures++;
        wrap_up();
      end
      k = n_tx + 2;
      step(1);
      rvalid = 1'b0;
      for (int w = 0; w < 50 && n_tx < k; w++)
        step(1);
      if (n_tx < k)
      begin
        failures++;
        wrap_up();
      end
      check(prev_c, rchar);
      check(last_c, term);
    end
    ring_run(8'h03, 4);
    ring_run(8'h01, 2);
    ring_run(8'h00, 260);
    wrap_up();
  end
endmodule
